// ---- bench/pccs_channel_monitor.sv ----
/*
  pccs_channel_monitor: port checks for pccs_channel.
  assumes: bound to every pccs_channel; clk_en held high by the bench.
*/
`timescale 1ns/1ns
module pccs_channel_monitor (
  input wire logic                    ref_clk,
  input wire logic                    rst_b,
  input wire pccs_pkg::pccs_cfg_type  cfg,
  input wire pccs_pkg::pccs_coef_type coef_ram_set,
  input wire logic signed [15:0]      input_path_gain,
  input wire logic signed [15:0]      scaling_gain,
  input wire logic signed [15:0]      analog_output,
  input wire logic                    loopback_active,
  input wire logic [15:0]             rx_sample,
  input wire logic                    rx_sample_valid,
  input wire logic                    rx_half_lsb,
  input wire pccs_pkg::pccs_coef_type coef_active
);
  int                      gain_exp;
  logic [4:0]              isc;
  pccs_pkg::pccs_coef_type rom_set;
  //////////////////////////////////////////////////////////////////////////////
  // the scaling code in force is the selected coefficient set's, not the config word's
  assign isc = coef_active.impedance_scaling_code;
  assign gain_exp = (int'(input_path_gain) * (int'(isc) - 16)) >>> 4;
  assign rom_set = {pccs_pkg::ROM_GX_WORD, pccs_pkg::ROM_GR_WORD, pccs_pkg::ROM_UNITY, pccs_pkg::ROM_UNITY,
                    pccs_pkg::ROM_ZERO, pccs_pkg::ROM_ZERO, 3'b000, pccs_pkg::ISC_CUTOFF};
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  //////////////////////////////////////////////////////////////////////////////
  // three steady cycles allow for the output register
  property p_gain;
    (isc != 5'h00 && isc != 5'h10 && $stable(coef_active)
      && $stable(input_path_gain))[*3] |-> scaling_gain == gain_exp[15:0];
  endproperty
  property p_cutoff;
    (isc == pccs_pkg::ISC_CUTOFF)[*3] |-> scaling_gain == 16'sh0000;
  endproperty
  property p_loop;
    (isc == pccs_pkg::ISC_LOOPBACK)[*3] |-> loopback_active && analog_output == 16'sh0000;
  endproperty
  property p_noloop;
    (isc != pccs_pkg::ISC_LOOPBACK)[*3] |-> !loopback_active;
  endproperty
  property p_half;
    rx_sample_valid && rx_half_lsb |->
      !rx_sample[0] && cfg.robbed_bit_mode_enable && cfg.coding == pccs_pkg::PCCS_CODE_ULAW;
  endproperty
  property p_pulse;
    rx_sample_valid |=> !rx_sample_valid;
  endproperty
  property p_rom;
    cfg.use_default_coef |-> coef_active == rom_set;
  endproperty
  property p_ram;
    !cfg.use_default_coef |-> coef_active == coef_ram_set;
  endproperty
  //////////////////////////////////////////////////////////////////////////////
  a_gain: assert property (p_gain)
    else $error("scaling gain off formula");
  a_cutoff: assert property (p_cutoff)
    else $error("cutoff gain not zero");
  a_loop: assert property (p_loop)
    else $error("loopback not formed");
  a_noloop: assert property (p_noloop)
    else $error("loopback outside its code");
  a_half: assert property (p_half)
    else $error("half lsb in wrong mode");
  a_pulse: assert property (p_pulse)
    else $error("sample valid too long");
  a_rom: assert property (p_rom)
    else $error("default set wrong");
  a_ram: assert property (p_ram)
    else $error("programmed set wrong");
  c_half: cover property (rx_sample_valid && rx_half_lsb);
  c_loop: cover property (loopback_active);
  c_rom: cover property (cfg.use_default_coef);
endmodule // pccs_channel_monitor

bind pccs_channel pccs_channel_monitor pccs_channel_monitor_i (.ref_clk, .rst_b, .cfg, .coef_ram_set,
  .input_path_gain, .scaling_gain, .analog_output, .loopback_active, .rx_sample, .rx_sample_valid,
  .rx_half_lsb, .coef_active);

// ---- bench/pccs_highway_model.sv ----
/*
  pccs_highway_model: pcm highway timing logic facing one channel.
  assumes: free running 64 ns bit clock; receive line carries all-ones bytes.
*/
`timescale 1ns/1ns
module pccs_highway_model #(
  parameter int FRAME_BITS = 32
) (
  output logic        pcm_clk,
  output logic        frame_sync_pulse,
  output logic        pcm_rx_data,
  input  wire logic   pcm_tx_data,
  input  wire logic   pcm_tx_enable_b,
  input  wire logic   fs_wide,
  input  wire logic   clr,
  output logic        frame_tick,
  output logic [15:0] cap_word,
  output int          cap_count
);
  int   bit_cnt = 0;
  logic cap_done = 1'b0;
  //////////////////////////////////////////////////////////////////////////////
  // all-ones bytes keep lsb checks free of slot alignment
  initial begin
    pcm_clk = 1'b0;
    frame_sync_pulse = 1'b0;
    pcm_rx_data = 1'b1;
    frame_tick = 1'b0;
    cap_word = '0;
    cap_count = 0;
    #5;
    forever #32 pcm_clk = ~pcm_clk;
  end
  always @(posedge pcm_clk) begin
    bit_cnt <= (bit_cnt == FRAME_BITS - 1) ? 0 : bit_cnt + 1;
    frame_tick <= (bit_cnt == FRAME_BITS - 1);
    frame_sync_pulse <= (bit_cnt == FRAME_BITS - 1) || (fs_wide && bit_cnt == 0);
  end
  // one burst per clear; sampling a rising edge late gives margin on both sides
  always @(posedge pcm_clk) begin
    if (clr) begin
      cap_word <= '0;
      cap_count <= 0;
      cap_done <= 1'b0;
    end else if (!cap_done && pcm_tx_enable_b === 1'b0) begin
      cap_word <= {cap_word[14:0], pcm_tx_data};
      cap_count <= cap_count + 1;
    end else if (cap_count != 0) begin
      cap_done <= 1'b1;
    end
  end
endmodule // pccs_highway_model

// ---- bench/tb_top.sv ----
/*
  tb_top: self-checking bench for pccs_channel on a modelled pcm highway.
  assumes: the monitor binds itself; clk_en stays high.
*/
`timescale 1ns/1ns
module tb_top;
  localparam pccs_pkg::pccs_code_type UL = pccs_pkg::PCCS_CODE_ULAW;
  localparam pccs_pkg::pccs_code_type AL = pccs_pkg::PCCS_CODE_ALAW;
  localparam pccs_pkg::pccs_code_type LN = pccs_pkg::PCCS_CODE_LINEAR;
  logic                    ref_clk = 1'b0;
  logic                    rst_b, clk_en, pcm_clk, frame_sync_pulse, pcm_rx_data, coef_wr, coef_rd;
  logic                    hook_detector_input, second_detector_input, multiplexed_detector_input;
  logic                    detector_mux_select, clock_failure_flag, pcm_tx_data, pcm_tx_enable_b;
  logic                    rx_sample_valid, rx_half_lsb, loopback_active, fs_wide, clr, frame_tick;
  logic [6:0]              tx_slot, rx_slot;
  logic [5:0]              coef_addr;
  logic [7:0]              tx_companded;
  logic [15:0]             tx_sample, coef_wr_data, coef_rd_data, rx_sample, cap_word;
  logic signed [15:0]      input_path_gain, analog_input, rx_feedback, scaling_gain, analog_output, lbi;
  pccs_pkg::pccs_cfg_type  cfg, rb;
  pccs_pkg::pccs_coef_type coef_ram_set, coef_active;
  int                      cap_count, errors = 0, n_compared = 0, cycles = 0;
  //////////////////////////////////////////////////////////////////////////////
  pccs_channel pccs_channel_i (.ref_clk, .rst_b, .clk_en, .cfg, .pcm_clk, .frame_sync_pulse, .pcm_rx_data,
    .tx_slot, .rx_slot, .hook_detector_input, .second_detector_input, .multiplexed_detector_input,
    .detector_mux_select, .clock_failure_flag, .tx_sample, .tx_companded, .coef_wr, .coef_rd, .coef_addr,
    .coef_wr_data, .coef_ram_set, .input_path_gain, .analog_input, .rx_feedback, .coef_rd_data, .pcm_tx_data,
    .pcm_tx_enable_b, .rx_sample, .rx_sample_valid, .rx_half_lsb, .scaling_gain, .scaled_feedback(),
    .analog_output, .loopback_input(lbi), .loopback_active, .coef_active);
  pccs_highway_model pccs_highway_model_i (.pcm_clk, .frame_sync_pulse, .pcm_rx_data, .pcm_tx_data,
    .pcm_tx_enable_b, .fs_wide, .clr, .frame_tick, .cap_word, .cap_count);
  always #4 ref_clk = ~ref_clk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ceiling well above the roughly 11k cycles the scenarios need
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  function automatic pccs_pkg::pccs_cfg_type cf(pccs_pkg::pccs_code_type k, logic sig, half, mcs, act);
    cf = '0;
    cf.coding = k;
    cf.highway_signaling_select = sig;
    cf.pcm_clock_halving_bit = half;
    cf.master_clock_source_select = mcs;
    cf.channel_active = act;
  endfunction
  function automatic logic [15:0] dup(logic [7:0] b);
    for (int i = 0; i < 8; i++)
      dup[2*i +: 2] = {2{b[i]}};
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  task automatic tx_case(input pccs_pkg::pccs_cfg_type c, input logic [15:0] exp, mask, input int cnt);
    @(posedge ref_clk);
    cfg <= c;
    clr <= 1'b1;
    repeat (2) @(posedge frame_tick);
    // a halved burst runs two bit clocks into the next frame
    repeat (4) @(posedge pcm_clk);
    @(posedge ref_clk);
    clr <= 1'b0;
    repeat (2) @(posedge frame_tick);
    @(negedge ref_clk);
    check(cap_word & mask, exp, "tx word");
    if (cnt > 0)
      check(cap_count[15:0], cnt[15:0], "tx bits");
  endtask
  task automatic rx_frame(input logic wide, input logic exp);
    int i;
    @(posedge frame_tick);
    @(posedge ref_clk);
    fs_wide <= wide;
    i = 0;
    do begin
      @(negedge ref_clk);
      i++;
    end while (rx_sample_valid !== 1'b1 && i < 400);
    check(rx_sample_valid, 1'b1, "rx valid");
    check(rx_half_lsb, exp, "half lsb");
    check(rx_sample, {8'h00, 7'h7f, !exp}, "rx byte");
  endtask
  task automatic scale_sweep();
    int e;
    for (int c = 0; c < 32; c++) begin
      @(posedge ref_clk);
      coef_ram_set.impedance_scaling_code <= c[4:0];
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
      e = 16 * (c - 16);
      if (c == 0)
        check(scaling_gain, 16'h0000, "cutoff gain");
      else if (c == 16) begin
        check(loopback_active, 1'b1, "loopback");
        check(analog_output, 16'h0000, "analog_output level");
        check(lbi, rx_feedback, "loop input");
      end else
        check(scaling_gain, e[15:0], "scaling gain");
    end
  endtask
  task automatic coef_io(input logic wr, input logic [5:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    coef_wr <= wr;
    coef_rd <= !wr;
    coef_addr <= a;
    coef_wr_data <= d;
    @(posedge ref_clk);
    coef_wr <= 1'b0;
    coef_rd <= 1'b0;
    @(negedge ref_clk);
    if (!wr)
      check(coef_rd_data, d, "coef read");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    cfg = cf(UL, 1'b0, 1'b0, 1'b0, 1'b1);
    {coef_wr, coef_rd, coef_addr, coef_wr_data, fs_wide, clr} = '0;
    {hook_detector_input, second_detector_input, multiplexed_detector_input} = 3'b101;
    {detector_mux_select, clock_failure_flag} = 2'b11;
    tx_slot = 7'h01;
    rx_slot = 7'h01;
    tx_sample = 16'ha5c3;
    tx_companded = 8'h3a;
    coef_ram_set = {16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h5555, 16'h6666, 8'h5a};
    input_path_gain = 16'sh0100;
    analog_input = 16'sh1234;
    rx_feedback = 16'sh0200;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    scale_sweep();
    tx_case(cf(UL, 0, 0, 0, 1), 16'h003a, 16'hffff, 8);
    tx_case(cf(AL, 0, 0, 0, 1), {8'h00, 8'h3a ^ pccs_pkg::ALAW_INVERT}, 16'hffff, 8);
    tx_case(cf(LN, 0, 0, 0, 1), 16'ha5c3, 16'hffff, 16);
    tx_case(cf(UL, 0, 1, 0, 1), dup(8'h3a), 16'hffff, 16);
    tx_case(cf(UL, 0, 1, 1, 1), dup(8'h3a), 16'hffff, 16);
    @(posedge ref_clk) tx_companded <= 8'h81;
    tx_case(cf(UL, 1, 0, 0, 1), 16'h81c4, 16'hffc4, 16);
    @(posedge ref_clk) detector_mux_select <= 1'b0;
    tx_case(cf(UL, 1, 0, 0, 0), 16'h0084, 16'h00c4, 0);
    rb = cf(UL, 0, 0, 0, 1);
    rb.robbed_bit_mode_enable = 1'b1;
    @(posedge ref_clk);
    cfg <= rb;
    rx_frame(1'b0, 1'b0);
    rx_frame(1'b1, 1'b1);
    rx_frame(1'b1, 1'b0);
    rx_frame(1'b0, 1'b0);
    rx_frame(1'b1, 1'b1);
    tx_case(rb, 16'h0081, 16'hffff, 8);
    rb.coding = AL;
    @(posedge ref_clk);
    cfg <= rb;
    rx_frame(1'b0, 1'b0);
    rx_frame(1'b1, 1'b0);
    rb = cf(UL, 0, 0, 0, 1);
    @(posedge ref_clk);
    cfg <= rb;
    rx_frame(1'b0, 1'b0);
    rx_frame(1'b1, 1'b0);
    @(posedge ref_clk) cfg.use_default_coef <= 1'b1;
    coef_io(1'b1, 6'h05, 16'hb0c1);
    coef_io(1'b0, 6'h05, 16'hb0c1);
    check(coef_active.transmit_gain_filter, pccs_pkg::ROM_GX_WORD, "default gx");
    check(coef_active.b_filter, 16'h0000, "default b");
    @(posedge ref_clk);
    cfg.use_default_coef <= 1'b0;
    @(negedge ref_clk);
    check(coef_active.b_filter, coef_ram_set.b_filter, "programmed b");
    end_of_test();
  end
endmodule // tb_top

// ---- include/pccs_pkg.sv ----
/*
  pccs_pkg: constants and carrier types for the per-channel pcm coding and
  highway signaling block.
  assumes: included before every design file of the block.
*/
package pccs_pkg;
  localparam logic [4:0]  ISC_CUTOFF       = 5'h00;
  localparam logic [4:0]  ISC_LOOPBACK     = 5'h10;
  localparam logic [4:0]  ISC_OFFSET       = 5'h10;
  localparam int          ISC_STEP_SHIFT   = 4;
  localparam int          SIG_HOOK_BIT     = 7;
  localparam int          SIG_DET2_BIT     = 6;
  localparam int          SIG_CLOCK_FAILURE_FLAG_BIT    = 2;
  localparam logic [7:0]  ALAW_INVERT      = 8'h55;
  localparam int          ROM_GX_CDB       = 600;
  localparam int          ROM_GR_MDB       = -8984;
  localparam logic [15:0] ROM_GX_WORD      = 16'h4000;
  localparam logic [15:0] ROM_GR_WORD      = 16'h1c63;
  localparam logic [15:0] ROM_UNITY        = 16'h4000;
  localparam logic [15:0] ROM_ZERO         = 16'h0000;
  localparam int          COEF_ADDR_W      = 6;
  localparam int          COEF_DATA_W      = 16;

  typedef enum logic [1:0] {
    PCCS_CODE_ULAW,
    PCCS_CODE_ALAW,
    PCCS_CODE_LINEAR
  } pccs_code_type;

  typedef struct packed {
    logic [4:0]    impedance_scaling_code;
    logic          pcm_clock_halving_bit;
    logic          master_clock_source_select;
    logic          highway_signaling_select;
    logic          robbed_bit_mode_enable;
    pccs_code_type coding;
    logic          use_default_coef;
    logic          channel_active;
  } pccs_cfg_type;

  typedef struct packed {
    logic hook_detector_input;
    logic second_detector_input;
    logic multiplexed_detector_input;
    logic mux_select;
    logic clock_failure_flag;
  } pccs_sig_type;

  typedef struct packed {
    logic [15:0] transmit_gain_filter;
    logic [15:0] receive_loss_filter;
    logic [15:0] r_filter;
    logic [15:0] x_filter;
    logic [15:0] z_filter;
    logic [15:0] b_filter;
    logic        transmit_analog_amp;
    logic        receive_analog_amp;
    logic        input_attenuator_disable;
    logic [4:0]  impedance_scaling_code;
  } pccs_coef_type;
endpackage

// ---- verilog/pccs_channel.sv ----
/*
  pccs_channel: one channel's coding, time-slot shifting, highway signaling,
  robbed-bit receive handling, impedance-scaling decode and coefficient select.
  assumes: pclk, fs, receive data and detector levels come from outside the
  ref_clk domain; configuration and coefficient port are on ref_clk.
*/
`timescale 1ns/1ns
module pccs_channel #(
  parameter int SLOT_BITS = 8
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst_b,
  input  wire logic                  clk_en,
  input  wire pccs_pkg::pccs_cfg_type cfg,
  input  wire logic                  pcm_clk,
  input  wire logic                  frame_sync_pulse,
  input  wire logic                  pcm_rx_data,
  input  wire logic [6:0]            tx_slot,
  input  wire logic [6:0]            rx_slot,
  input  wire logic                  hook_detector_input,
  input  wire logic                  second_detector_input,
  input  wire logic                  multiplexed_detector_input,
  input  wire logic                  detector_mux_select,
  input  wire logic                  clock_failure_flag,
  input  wire logic [15:0]           tx_sample,
  input  wire logic [7:0]            tx_companded,
  input  wire logic                  coef_wr,
  input  wire logic                  coef_rd,
  input  wire logic [5:0]            coef_addr,
  input  wire logic [15:0]           coef_wr_data,
  input  wire pccs_pkg::pccs_coef_type coef_ram_set,
  input  wire logic signed [15:0]    input_path_gain,
  input  wire logic signed [15:0]    analog_input,
  input  wire logic signed [15:0]    rx_feedback,
  output logic      [15:0]           coef_rd_data,
  output logic                       pcm_tx_data,
  output logic                       pcm_tx_enable_b,
  output logic      [15:0]           rx_sample,
  output logic                       rx_sample_valid,
  output logic                       rx_half_lsb,
  output logic signed [15:0]         scaling_gain,
  output logic signed [15:0]         scaled_feedback,
  output logic signed [15:0]         analog_output,
  output logic signed [15:0]         loopback_input,
  output logic                       loopback_active,
  output pccs_pkg::pccs_coef_type    coef_active
);
  //////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [1:0] pclk_sync_r;
  logic [1:0] fs_sync_r;
  logic [1:0] rxd_sync_r;
  logic [1:0] hook_sync_r;
  logic [1:0] det2_sync_r;
  logic [1:0] detm_sync_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pclk_sync_r <= 2'h0;
      fs_sync_r   <= 2'h0;
      rxd_sync_r  <= 2'h0;
      hook_sync_r <= 2'h0;
      det2_sync_r <= 2'h0;
      detm_sync_r <= 2'h0;
    end else if (clk_en) begin
      pclk_sync_r <= {pclk_sync_r[0], pcm_clk};
      fs_sync_r   <= {fs_sync_r[0], frame_sync_pulse};
      rxd_sync_r  <= {rxd_sync_r[0], pcm_rx_data};
      hook_sync_r <= {hook_sync_r[0], hook_detector_input};
      det2_sync_r <= {det2_sync_r[0], second_detector_input};
      detm_sync_r <= {detm_sync_r[0], multiplexed_detector_input};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bit clock edges and frame sync width
  logic pclk_fall;
  logic pclk_rise;
  logic frame_start;
  logic fs_two_long;
  logic fs_done;

  pccs_fs_detect u_fs (
    .ref_clk     (ref_clk),
    .rst_b       (rst_b),
    .clk_en      (clk_en),
    .pclk_s      (pclk_sync_r[1]),
    .fs_s        (fs_sync_r[1]),
    .pclk_fall   (pclk_fall),
    .pclk_rise   (pclk_rise),
    .frame_start (frame_start),
    .fs_two_long (fs_two_long),
    .fs_done     (fs_done)
  );

  //////////////////////////////////////////////////////////////////////////////
  // clock halving inside the slot assigner only
  logic half_ph_r;
  logic bit_tick;
  logic fall_tick;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      half_ph_r <= 1'b0;
    end else if (clk_en) begin
      if (frame_start) begin
        half_ph_r <= 1'b0;
      end else if (pclk_rise) begin
        half_ph_r <= ~half_ph_r;
      end
    end
  end

  // halve data tick
  // master clock source select does not reach this divider, so either source works
  assign bit_tick  = pclk_rise & (~cfg.pcm_clock_halving_bit | half_ph_r);
  assign fall_tick = pclk_fall & (~cfg.pcm_clock_halving_bit | half_ph_r);

  //////////////////////////////////////////////////////////////////////////////
  // frame bit counter
  logic [10:0] bit_cnt_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      bit_cnt_r <= 11'h000;
    end else if (clk_en) begin
      if (frame_start) begin
        bit_cnt_r <= 11'h000;
      end else if (bit_tick) begin
        bit_cnt_r <= bit_cnt_r + 11'h001;
      end
    end
  end

  function automatic logic [10:0] slot_base(input logic [6:0] slot);
    slot_base = {slot, 4'h0} >> 1;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // transmit word build
  logic        two_slots;
  logic [15:0] tx_word;
  logic [7:0]  sig_byte;
  logic [7:0]  tx_byte;

  assign tx_byte   = (cfg.coding == pccs_pkg::PCCS_CODE_ALAW) ? (tx_companded ^ pccs_pkg::ALAW_INVERT)
                                                               : tx_companded;
  always_comb begin
    sig_byte = 8'h00;
    sig_byte[pccs_pkg::SIG_HOOK_BIT]  = hook_sync_r[1];
    sig_byte[pccs_pkg::SIG_DET2_BIT]  = detector_mux_select ? detm_sync_r[1] : det2_sync_r[1];
    sig_byte[pccs_pkg::SIG_CLOCK_FAILURE_FLAG_BIT] = clock_failure_flag;
  end

  always_comb begin
    tx_word = {tx_byte, 8'h00};
    case (cfg.coding)
      pccs_pkg::PCCS_CODE_LINEAR: tx_word = tx_sample;
      default:                    tx_word = {tx_byte, sig_byte};
    endcase
  end

  assign two_slots = cfg.coding == pccs_pkg::PCCS_CODE_LINEAR | cfg.highway_signaling_select;

  //////////////////////////////////////////////////////////////////////////////
  // transmit shifter
  logic [15:0] tx_shift_r;
  logic        tx_on_r;
  logic [10:0] tx_start;
  logic [10:0] tx_len;

  assign tx_start = slot_base(tx_slot);
  assign tx_len   = two_slots ? 11'h010 : 11'h008;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      tx_shift_r <= 16'h0000;
      tx_on_r    <= 1'b0;
    end else if (clk_en) begin
      if (bit_tick) begin
        if (bit_cnt_r == tx_start & (cfg.channel_active | cfg.highway_signaling_select)) begin
          tx_shift_r <= tx_word;
          tx_on_r    <= 1'b1;
        end else if (tx_on_r & (bit_cnt_r - tx_start) >= tx_len) begin
          tx_on_r <= 1'b0;
        end else begin
          tx_shift_r <= {tx_shift_r[14:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pcm_tx_data     <= 1'b0;
      pcm_tx_enable_b <= 1'b1;
    end else if (clk_en) begin
      pcm_tx_data     <= tx_shift_r[15];
      pcm_tx_enable_b <= ~tx_on_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receive shifter and robbed-bit frame marking
  logic [15:0] rx_shift_r;
  logic [4:0]  rx_got_r;
  logic        prev_two_r;
  logic        robbed_r;
  logic [10:0] rx_start;
  logic        rx_in;
  logic        ulaw;

  assign ulaw     = cfg.coding == pccs_pkg::PCCS_CODE_ULAW;
  assign rx_start = slot_base(rx_slot);
  assign rx_in    = bit_cnt_r >= rx_start & (bit_cnt_r - rx_start) < (two_slots ? 11'h010 : 11'h008);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      prev_two_r <= 1'b0;
      robbed_r   <= 1'b0;
    end else if (clk_en) begin
      if (fs_done) begin
        robbed_r   <= cfg.robbed_bit_mode_enable & ulaw & fs_two_long & ~prev_two_r;
        prev_two_r <= fs_two_long;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rx_shift_r      <= 16'h0000;
      rx_got_r        <= 5'h00;
      rx_sample       <= 16'h0000;
      rx_sample_valid <= 1'b0;
      rx_half_lsb     <= 1'b0;
    end else if (clk_en) begin
      rx_sample_valid <= 1'b0;
      if (frame_start) begin
        rx_got_r <= 5'h00;
      end else if (fall_tick & rx_in) begin
        rx_shift_r <= {rx_shift_r[14:0], rxd_sync_r[1]};
        rx_got_r   <= rx_got_r + 5'h01;
        if (rx_got_r == 5'h07 & cfg.coding != pccs_pkg::PCCS_CODE_LINEAR) begin
          rx_sample       <= {8'h00, rx_shift_r[6:0], robbed_r ? 1'b0 : rxd_sync_r[1]};
          rx_half_lsb     <= robbed_r;
          rx_sample_valid <= 1'b1;
        end else if (rx_got_r == 5'h0f & cfg.coding == pccs_pkg::PCCS_CODE_LINEAR) begin
          rx_sample       <= {rx_shift_r[14:0], rxd_sync_r[1]};
          rx_half_lsb     <= 1'b0;
          rx_sample_valid <= 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // impedance scaling decode
  logic signed [21:0] gain_prod;
  logic signed [5:0]  step;

  assign step      = $signed({1'b0, coef_active.impedance_scaling_code}) - $signed({1'b0, pccs_pkg::ISC_OFFSET});
  assign gain_prod = 22'(input_path_gain) * 22'(step);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      scaling_gain    <= 16'sh0000;
      loopback_active <= 1'b0;
    end else if (clk_en) begin
      loopback_active <= coef_active.impedance_scaling_code == pccs_pkg::ISC_LOOPBACK;
      if (coef_active.impedance_scaling_code == pccs_pkg::ISC_CUTOFF) begin
        scaling_gain <= 16'sh0000;
      end else if (coef_active.impedance_scaling_code == pccs_pkg::ISC_LOOPBACK) begin
        scaling_gain <= 16'sh0000;
      end else begin
        scaling_gain <= 16'(gain_prod >>> pccs_pkg::ISC_STEP_SHIFT);
      end
    end
  end

  logic signed [31:0] fb_prod;
  assign fb_prod = 32'(scaling_gain) * 32'(analog_input);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      scaled_feedback <= 16'sh0000;
      analog_output   <= 16'sh0000;
      loopback_input  <= 16'sh0000;
    end else if (clk_en) begin
      scaled_feedback <= 16'(fb_prod >>> 15);
      if (loopback_active) begin
        // loop at 0 dB, input ignored, output at reference
        loopback_input <= rx_feedback;
        analog_output  <= 16'sh0000;
      end else begin
        loopback_input <= analog_input;
        analog_output  <= rx_feedback + 16'(fb_prod >>> 15);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // coefficient selection and readback
  always_comb begin
    coef_active = coef_ram_set;
    if (cfg.use_default_coef) begin
      coef_active.transmit_gain_filter     = pccs_pkg::ROM_GX_WORD;
      coef_active.receive_loss_filter      = pccs_pkg::ROM_GR_WORD;
      coef_active.r_filter                 = pccs_pkg::ROM_UNITY;
      coef_active.x_filter                 = pccs_pkg::ROM_UNITY;
      coef_active.z_filter                 = pccs_pkg::ROM_ZERO;
      coef_active.b_filter                 = pccs_pkg::ROM_ZERO;
      coef_active.transmit_analog_amp      = 1'b0;
      coef_active.receive_analog_amp       = 1'b0;
      coef_active.input_attenuator_disable = 1'b0;
      coef_active.impedance_scaling_code   = pccs_pkg::ISC_CUTOFF;
    end
  end

  pccs_coef_mem u_mem (
    .ref_clk (ref_clk),
    .clk_en  (clk_en),
    .wr_en   (coef_wr),
    .addr    (coef_addr),
    .wr_data (coef_wr_data),
    .rd_data (coef_rd_data)
  );
endmodule // pccs_channel

// ---- verilog/pccs_coef_mem.sv ----
/*
  pccs_coef_mem: programmable coefficient ram, registered read data.
  assumes: single clock; never-written words read as whatever the array holds.
*/
`timescale 1ns/1ns
module pccs_coef_mem #(
  parameter int AW = pccs_pkg::COEF_ADDR_W,
  parameter int DW = pccs_pkg::COEF_DATA_W
) (
  input  wire logic          ref_clk,
  input  wire logic          clk_en,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wr_data,
  output logic      [DW-1:0] rd_data
);
  // no reset on the array: unwritten contents stay undefined
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      if (wr_en) begin
        mem[addr] <= wr_data;
      end
      rd_data <= mem[addr];
    end
  end
endmodule // pccs_coef_mem

// ---- verilog/pccs_fs_detect.sv ----
/*
  pccs_fs_detect: finds rising and falling pcm bit clock edges and measures frame sync width.
  assumes: pclk and fs already pass a two-flop synchroniser upstream.
*/
`timescale 1ns/1ns
module pccs_fs_detect (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic clk_en,
  input  wire logic pclk_s,
  input  wire logic fs_s,
  output logic      pclk_fall,
  output logic      pclk_rise,
  output logic      frame_start,
  output logic      fs_two_long,
  output logic      fs_done
);
  logic       pclk_d_r;
  logic [2:0] fs_hist_r;
  logic       in_pulse_r;

  assign pclk_fall = pclk_d_r & ~pclk_s;
  assign pclk_rise = ~pclk_d_r & pclk_s;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pclk_d_r   <= 1'b0;
      fs_hist_r  <= 3'h0;
      in_pulse_r <= 1'b0;
    end else if (clk_en) begin
      pclk_d_r <= pclk_s;
      if (pclk_fall) begin
        fs_hist_r  <= {fs_hist_r[1:0], fs_s};
        in_pulse_r <= fs_s;
      end
    end
  end

  assign frame_start = pclk_fall & fs_s & ~in_pulse_r;
  assign fs_done     = pclk_fall & ~fs_s & fs_hist_r[0];
  assign fs_two_long = fs_hist_r[1:0] == 2'b11 & ~fs_hist_r[2];
endmodule // pccs_fs_detect
